//--- six_bit_port_pad_control_tb_top.sv
// Self-checking bench for the six-bit port pad control
`timescale 1ns/1ps
module six_bit_port_pad_control_tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e;
	logic [5:0] pin_in, pin_out, pin_oe_n, pin_slow, pin_pull_up, analog_out, analog_pass;
	logic [5:0] ext = 6'h00;
	logic [5:0] analog_in = 6'h00;
	logic [5:0] f, l, d;
	int miscompares = 0;
	int comparisons = 0;
	always #50 ref_clk = ~ref_clk;
	spd_port dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pin_in, .pin_out, .pin_oe_n, .pin_slow, .pin_pull_up, .analog_in,
		.analog_out, .analog_pass);
	spd_pad_model model (.pin_out, .pin_oe_n, .pin_pull_up, .ext_level(ext), .pin_in);
	// ************
	// Helpers
	// ************
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Packed as oe_n, out, slow, pull, pass, invert
	function automatic logic [5:0] exp_pad(input logic [2:0] c);
		case (c)
			3'h0: exp_pad = 6'h22;
			3'h2: exp_pad = 6'h24;
			3'h3: exp_pad = 6'h10;
			3'h4: exp_pad = 6'h08;
			3'h6: exp_pad = 6'h18;
			3'h7: exp_pad = 6'h23;
			default: exp_pad = 6'h00;
		endcase
	endfunction
	task automatic chk_cfg(input logic [5:0] cf, cl, cd, input logic rd);
		logic [5:0] eo, ev, es, ep, ea, ei, lv;
		for (int i = 0; i < 6; i++) begin
			{eo[i], ev[i], es[i], ep[i], ea[i], ei[i]} = exp_pad({cf[i], cl[i], cd[i]});
		end
		lv = (~eo & ev) | (eo & ep) | (eo & ~ep & ext);
		chk("oe_n", pin_oe_n, eo);
		chk("out", pin_out & ~eo, ev);
		chk("slow", pin_slow, es);
		chk("pull", pin_pull_up, ep);
		chk("pass", analog_pass, ea);
		chk("aout", analog_out, analog_in & ea);
		if (rd) begin
			apb(1'b0, 12'h004, 32'h0);
			chk("input", r, lv ^ ei);
		end
	endtask
	task automatic cfg(input logic [5:0] cf, cl, cd);
		apb(1'b1, 12'h000, {26'($urandom), cl});
		apb(1'b1, 12'h008, {26'($urandom), cd});
		apb(1'b1, 12'h00C, {26'($urandom), cf});
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic rdcfg(input logic [5:0] cf, cl, cd);
		apb(1'b0, 12'h000, 32'h0);
		chk("latch", r, {26'h0, cl});
		apb(1'b0, 12'h008, 32'h0);
		chk("dir", r, {26'h0, cd});
		apb(1'b0, 12'h00C, 32'h0);
		chk("fsel", r, {26'h0, cf});
	endtask
	task end_of_test;
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ************
	// Main sequence
	// ************
	initial begin
		void'($urandom(34596));
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_cfg(6'h00, 6'h00, 6'h00, 1'b1);
		rdcfg(6'h00, 6'h00, 6'h00);
		// First two cover all eight codes
		for (int k = 0; k < 44; k++) begin
			f = (k == 0) ? 6'h30 : (k == 1) ? 6'h3C : 6'($urandom);
			l = (k == 0) ? 6'h0C : (k == 1) ? 6'h33 : 6'($urandom);
			d = (k < 2) ? 6'h2A : 6'($urandom);
			ext <= 6'($urandom);
			analog_in <= 6'($urandom);
			cfg(f, l, d);
			chk_cfg(f, l, d, 1'b1);
			rdcfg(f, l, d);
		end
		for (int b = 0; b < 3; b++) begin
			apb(1'b1, 12'h010, 32'(1 << b));
			apb(1'b0, 12'h010, 32'h0);
			chk("stby", r, 32'(1 << b));
			cfg(~f, ~l, ~d);
			chk_cfg(f, l, d, 1'b0);
			apb(1'b1, 12'h010, 32'h0);
			repeat (3) @(posedge ref_clk);
			{f, l, d} = {~f, ~l, ~d};
			chk_cfg(f, l, d, 1'b1);
		end
		apb(1'b1, 12'h014, 32'h3F);
		chk("werr", e, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk("err", e, 32'h1);
		chk("rdata", r, 32'h0);
		rdcfg(f, l, d);
		// Mid-run reset must clear a busy configuration and standby
		apb(1'b1, 12'h010, 32'h5);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_cfg(6'h00, 6'h00, 6'h00, 1'b1);
		rdcfg(6'h00, 6'h00, 6'h00);
		apb(1'b0, 12'h010, 32'h0);
		chk("stby", r, 32'h0);
		end_of_test;
	end
	// Run needs about 1200 cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		miscompares++;
		end_of_test;
	end
endmodule

//--- spd_defs.svh
// Register offsets, reset values and field widths of the six-bit port
`ifndef SPD_DEFS_SVH
`define SPD_DEFS_SVH
// ************************************************************
// Register byte offsets
// ************************************************************
`define SPD_OFS_LATCH 12'h000
`define SPD_OFS_INPUT 12'h004
`define SPD_OFS_DIR 12'h008
`define SPD_OFS_FSEL 12'h00C
`define SPD_OFS_STANDBY 12'h010
// ************************************************************
// Widths and reset values
// ************************************************************
`define SPD_PINS 6
`define SPD_CTRL_RST 6'h00
`define SPD_STBY_BITS 3
`define SPD_STBY_RST 3'h0
`define SPD_PAD_OFF 6'h00
`define SPD_PAD_IDLE 6'h3F
`endif

//--- spd_pad_if.sv
// Per-pin control bits carried from the register file to each pad slice
`timescale 1ns/1ps
interface spd_pad_if;
	logic fsel;
	logic latch;
	logic dir;
	logic pin_level;
	logic drv_val;
	logic drv_oe_n;
	logic slow;
	logic pull_up;
	logic analog_pass;
	logic read_val;
	modport ctrl (output fsel, output latch, output dir, output pin_level,
		input drv_val, input drv_oe_n, input slow, input pull_up, input analog_pass,
		input read_val);
	modport slice (input fsel, input latch, input dir, input pin_level,
		output drv_val, output drv_oe_n, output slow, output pull_up, output analog_pass,
		output read_val);
endinterface

//--- spd_pad_model.sv
// Model of the pins and the board beyond them
`timescale 1ns/1ps
module spd_pad_model (
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe_n,
	input wire logic [5:0] pin_pull_up,
	input wire logic [5:0] ext_level,
	output logic [5:0] pin_in
);
	// Undriven pins follow the board driver unless pulled up
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & pin_pull_up)
		| (pin_oe_n & ~pin_pull_up & ext_level);
endmodule

//--- spd_pad_slice.sv
// Eight-way pad decode for one pin
`timescale 1ns/1ps
module spd_pad_slice
	import spd_pkg::*;
(
	spd_pad_if.slice pad
);
	spd_mode_e mode;
	always_comb begin
		case ({pad.fsel, pad.latch, pad.dir})
			3'h0: mode = SPD_OPEN_ANALOG;
			3'h2: mode = SPD_PULL_UP;
			3'h1, 3'h5: mode = SPD_DRIVE_LOW;
			3'h3: mode = SPD_DRIVE_HIGH;
			3'h4: mode = SPD_SLOW_LOW;
			3'h6: mode = SPD_SLOW_HIGH;
			3'h7: mode = SPD_OPEN_INVERT;
			default: mode = SPD_MODE_OTHER;
		endcase
	end
	always_comb begin
		pad.drv_val = 1'b0;
		pad.drv_oe_n = 1'b1;
		pad.slow = 1'b0;
		pad.pull_up = 1'b0;
		pad.analog_pass = 1'b0;
		pad.read_val = pad.pin_level;
		case (mode)
			SPD_OPEN_ANALOG: pad.analog_pass = 1'b1;
			SPD_PULL_UP: pad.pull_up = 1'b1;
			SPD_DRIVE_LOW: pad.drv_oe_n = 1'b0;
			SPD_DRIVE_HIGH: begin
				pad.drv_oe_n = 1'b0;
				pad.drv_val = 1'b1;
			end
			SPD_SLOW_LOW: begin
				pad.drv_oe_n = 1'b0;
				pad.slow = 1'b1;
			end
			SPD_SLOW_HIGH: begin
				pad.drv_oe_n = 1'b0;
				pad.slow = 1'b1;
				pad.drv_val = 1'b1;
			end
			SPD_OPEN_INVERT: begin
				pad.analog_pass = 1'b1;
				pad.read_val = ~pad.pin_level;
			end
			default: pad.drv_oe_n = 1'b1;
		endcase
	end
endmodule

//--- spd_pkg.sv
// Types shared by the six-bit port pad control
package spd_pkg;
	typedef enum logic [7:0] {
		SPD_OPEN_ANALOG = 8'h01,
		SPD_PULL_UP = 8'h02,
		SPD_DRIVE_LOW = 8'h04,
		SPD_DRIVE_HIGH = 8'h08,
		SPD_SLOW_LOW = 8'h10,
		SPD_SLOW_HIGH = 8'h20,
		SPD_OPEN_INVERT = 8'h40,
		SPD_MODE_OTHER = 8'h80
	} spd_mode_e;
endpackage

//--- spd_port.sv
// Six-bit port pad control with APB register access
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "spd_defs.svh"
module spd_port
	import spd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] pin_in,
	output logic [5:0] pin_out,
	output logic [5:0] pin_oe_n,
	output logic [5:0] pin_slow,
	output logic [5:0] pin_pull_up,
	input wire logic [5:0] analog_in,
	output logic [5:0] analog_out,
	output logic [5:0] analog_pass
);
	// ************************************************************
	// Register file
	// ************************************************************
	logic [5:0] latch_r, latch_nxt, dir_r, dir_nxt, fsel_r, fsel_nxt;
	logic [2:0] stby_r, stby_nxt;
	logic [5:0] in_r, in_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [5:0] read_val;
	logic setup, access, mapped;
	assign setup = psel && !penable;
	assign access = psel && penable && pready_r;
	always_comb begin
		case (paddr)
			`SPD_OFS_LATCH, `SPD_OFS_INPUT, `SPD_OFS_DIR, `SPD_OFS_FSEL,
			`SPD_OFS_STANDBY: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	always_comb begin
		latch_nxt = latch_r;
		dir_nxt = dir_r;
		fsel_nxt = fsel_r;
		stby_nxt = stby_r;
		prdata_nxt = prdata_r;
		pready_nxt = setup;
		pslverr_nxt = setup && !mapped;
		in_nxt = read_val;
		if (setup && !pwrite) begin
			case (paddr)
				`SPD_OFS_LATCH: prdata_nxt = {26'h0, latch_r};
				`SPD_OFS_INPUT: prdata_nxt = {26'h0, in_r};
				`SPD_OFS_DIR: prdata_nxt = {26'h0, dir_r};
				`SPD_OFS_FSEL: prdata_nxt = {26'h0, fsel_r};
				`SPD_OFS_STANDBY: prdata_nxt = {29'h0, stby_r};
				default: prdata_nxt = 32'h0;
			endcase
		end
		if (access && pwrite) begin
			case (paddr)
				`SPD_OFS_LATCH: latch_nxt = pwdata[5:0];
				`SPD_OFS_DIR: dir_nxt = pwdata[5:0];
				`SPD_OFS_FSEL: fsel_nxt = pwdata[5:0];
				`SPD_OFS_STANDBY: stby_nxt = pwdata[2:0];
				default: latch_nxt = latch_r;
			endcase
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			latch_r <= `SPD_CTRL_RST;
			dir_r <= `SPD_CTRL_RST;
			fsel_r <= `SPD_CTRL_RST;
			stby_r <= `SPD_STBY_RST;
			in_r <= `SPD_PAD_OFF;
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			latch_r <= latch_nxt;
			dir_r <= dir_nxt;
			fsel_r <= fsel_nxt;
			stby_r <= stby_nxt;
			in_r <= in_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	// ************************************************************
	// Pad slices
	// ************************************************************
	logic [5:0] d_val, d_oe_n, d_slow, d_pull, d_pass;
	genvar g;
	generate
		for (g = 0; g < `SPD_PINS; g++) begin : g_pin
			spd_pad_if pif ();
			assign pif.fsel = fsel_r[g];
			assign pif.latch = latch_r[g];
			assign pif.dir = dir_r[g];
			assign pif.pin_level = pin_in[g];
			assign d_val[g] = pif.drv_val;
			assign d_oe_n[g] = pif.drv_oe_n;
			assign d_slow[g] = pif.slow;
			assign d_pull[g] = pif.pull_up;
			assign d_pass[g] = pif.analog_pass;
			assign read_val[g] = pif.read_val;
			spd_pad_slice u_slice (.pad(pif));
		end
	endgenerate
	// ************************************************************
	// Pad output registers
	// ************************************************************
	// Any standby bit freezes the pads; the registers may still change
	logic hold;
	logic [5:0] out_r, out_nxt, oe_n_r, oe_n_nxt, slow_r, slow_nxt;
	logic [5:0] pull_r, pull_nxt, pass_r, pass_nxt, aout_r, aout_nxt;
	assign hold = |stby_r;
	always_comb begin
		out_nxt = out_r;
		oe_n_nxt = oe_n_r;
		slow_nxt = slow_r;
		pull_nxt = pull_r;
		pass_nxt = pass_r;
		aout_nxt = aout_r;
		if (!hold) begin
			out_nxt = d_val;
			oe_n_nxt = d_oe_n;
			slow_nxt = d_slow;
			pull_nxt = d_pull;
			pass_nxt = d_pass;
			aout_nxt = analog_in & d_pass;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			// Reset pads match the all-zero config: open, analog passed, except analog_out held at zero
			out_r <= `SPD_PAD_OFF;
			oe_n_r <= `SPD_PAD_IDLE;
			slow_r <= `SPD_PAD_OFF;
			pull_r <= `SPD_PAD_OFF;
			pass_r <= `SPD_PAD_IDLE;
			aout_r <= `SPD_PAD_OFF;
		end else begin
			out_r <= out_nxt;
			oe_n_r <= oe_n_nxt;
			slow_r <= slow_nxt;
			pull_r <= pull_nxt;
			pass_r <= pass_nxt;
			aout_r <= aout_nxt;
		end
	end
	assign pin_out = out_r;
	assign pin_oe_n = oe_n_r;
	assign pin_slow = slow_r;
	assign pin_pull_up = pull_r;
	assign analog_pass = pass_r;
	assign analog_out = aout_r;
	// ************************************************************
	// Assertions
	// ************************************************************
	a_reg_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
		pready && !pslverr |-> prdata[31:6] == 26'h0) else $error("upper bits set");
	a_open_analog: assert property (@(posedge ref_clk) disable iff (rst)
		!hold && fsel_r[0] == 0 && latch_r[0] == 0 && dir_r[0] == 0 |=> pin_oe_n[0] && analog_pass[0])
		else $error("open mode wrong");
	a_pull_up: assert property (@(posedge ref_clk) disable iff (rst)
		!hold && !fsel_r[1] && latch_r[1] && !dir_r[1] |=> pin_pull_up[1] && pin_oe_n[1]
		&& !analog_pass[1]) else $error("pull-up wrong");
	a_drive_low: assert property (@(posedge ref_clk) disable iff (rst)
		!hold && dir_r[2] && !latch_r[2] |=> !pin_oe_n[2] && !pin_out[2] && !pin_slow[2])
		else $error("drive low wrong");
	a_drive_high: assert property (@(posedge ref_clk) disable iff (rst)
		!hold && !fsel_r[3] && latch_r[3] && dir_r[3] |=> !pin_oe_n[3] && pin_out[3])
		else $error("drive high wrong");
	a_slow_low: assert property (@(posedge ref_clk) disable iff (rst)
		!hold && fsel_r[4] && !latch_r[4] && !dir_r[4] |=> pin_slow[4] && !pin_out[4]
		&& !pin_oe_n[4]) else $error("slow low wrong");
	a_slow_high: assert property (@(posedge ref_clk) disable iff (rst)
		!hold && fsel_r[5] && latch_r[5] && !dir_r[5] |=> pin_slow[5] && pin_out[5])
		else $error("slow high wrong");
	a_invert_read: assert property (@(posedge ref_clk) disable iff (rst)
		fsel_r[0] && latch_r[0] && dir_r[0] |=> in_r[0] == !$past(pin_in[0]))
		else $error("inverted read wrong");
	a_hold_freeze: assert property (@(posedge ref_clk) disable iff (rst)
		hold |=> $stable(pin_oe_n) && $stable(pin_out)) else $error("pads moved in standby");
	// ************************************************************
	// Standby entry and exit
	// ************************************************************
	// Entry is checked on every pad output except analog_out, not only drive and value
	sequence s_stby_entry;
		!hold ##1 hold;
	endsequence
	sequence s_stby_exit;
		hold ##1 !hold;
	endsequence
	a_hold_entry: assert property (@(posedge ref_clk) disable iff (rst)
		s_stby_entry |=> $stable(pin_slow) && $stable(pin_pull_up)
		&& $stable(analog_pass)) else $error("pads moved on standby entry");
	a_hold_exit: assert property (@(posedge ref_clk) disable iff (rst)
		s_stby_exit |=> pin_oe_n == $past(d_oe_n) && pin_out == $past(d_val))
		else $error("pads not released after standby");
	// Analog passes only where all three control bits agree
	a_pass_decode: assert property (@(posedge ref_clk) disable iff (rst)
		!hold |=> analog_pass == (~($past(fsel_r) ^ $past(latch_r))
		& ~($past(latch_r) ^ $past(dir_r)))) else $error("analog pass decode wrong");
endmodule
